// >>> rtl/bulk_ep_one_defs.vh
// Constants for the bulk endpoint one control block.
// Assumes an 8-bit local register port with separate read and write addresses.
`ifndef BULK_EP_ONE_DEFS_VH
`define BULK_EP_ONE_DEFS_VH

// Register read and write addresses
`define CTRL_RD_ADDR 8'he4
`define CTRL_WR_ADDR 8'h64
`define TGL_RD_ADDR 8'he5
`define TGL_WR_ADDR 8'h65
`define MPS_RD_ADDR 8'he6
`define MPS_WR_ADDR 8'h66

// Control register fields
`define CTRL_CFG_BIT 7
`define CTRL_FIXED_HI 6
`define CTRL_FIXED_LO 2
`define CTRL_STALL_BIT 0
`define CTRL_DIR_BIT 1
`define CTRL_FIXED_VAL 5'h06
`define CTRL_RESET 8'h18

// Toggle and packet size fields
`define TGL_BIT 0
`define MPS_WIDTH 7
`define MPS_RESET 7'h40

// Handshake codes on the packet engine port
`define HS_NONE 2'h0
`define HS_ACK 2'h1
`define HS_NAK 2'h2
`define HS_STALL 2'h3

`endif

// >>> rtl/bulk_ep_one_ctrl.v
// Control, toggle and packet size registers of bulk endpoint one.
// Assumes a packet engine on I_CLK and a level-sampled local register port.
//
// Summary of operation
// [RQ1] Transfer type bulk, address one, writes ignored
// [RQ2] Direction bit: zero receives, one transmits
// [RQ3] Stalled endpoint withholds packet-ready and interrupt
// [RQ4] Writing toggle one resets sequence to DATA0
// [RQ5] Sequence toggles automatically after each good transaction
// [RQ6] Upper seven toggle bits read zero
// [RQ7] Software loads size from selected descriptor
// [RQ8] Size is one of 64, 32, 16, 8; the code stores any 7-bit value written
// [RQ9] Size is a byte count for full packets
// [RQ10] Oversize receive: no ready, stall, STALL handshake
// [RQ11] Transmit ready after full-size DMA load
// [RQ12] Size register top bit reads zero
// [RQ13] Configuration bit gates all endpoint traffic; the code does not gate DMA transmit loads
// [RQ14] Stall bit forces STALL on every packet
`timescale 1ns/1ns
`default_nettype none
`include "bulk_ep_one_defs.vh"

module bulk_ep_one_ctrl #(
    parameter MPS_W = `MPS_WIDTH
) (
    input wire I_CLK,               // Core clock, 100 MHz
    input wire I_SYS_RST,           // Hardware reset, synchronous, high
    input wire I_BUS_RST,           // USB bus reset from the serial engine
    input wire I_CS_N,              // Register chip select, low active
    input wire I_RD_N,              // Register read strobe, low active
    input wire I_WR_N,              // Register write strobe, low active
    input wire [7:0] I_ADDR,        // Register address
    input wire [7:0] I_WDATA,       // Register write data
    output reg [7:0] O_RDATA,       // Register read data
    input wire I_TOKEN,             // Token for this endpoint seen, pulse
    input wire I_TOKEN_IN,          // Token is IN (host reads)
    input wire I_RX_BYTE,           // One data byte received, pulse
    input wire I_RX_EOP,            // End of received data packet, pulse
    input wire I_RX_PID_DATA1,      // Received packet carried DATA1
    input wire I_HOST_ACK,          // Host ACK after our data packet, pulse
    input wire I_DMA_BYTE,          // DMA wrote one byte to transmit buffer
    input wire I_TX_CLR,            // Transmit buffer consumed, pulse
    input wire I_RX_CLR,            // Receive buffer read out, pulse
    output reg O_RESPOND,           // Endpoint takes part in the token
    output reg [1:0] O_HANDSHAKE,   // Handshake to send, valid with O_HS_VALID
    output reg O_HS_VALID,          // Handshake strobe, pulse
    output reg O_TX_PID_DATA1,      // PID of next transmitted data packet
    output reg O_RX_READY,          // Receive packet-ready status
    output reg O_TX_READY,          // Transmit packet-ready status
    output reg O_IRQ_OUTPUT,        // Interrupt request for this endpoint
    output reg O_DIR_TX,            // Current direction, one transmits
    output reg O_STALLED            // Stall bit state
);

    // =========================================================
    // Register port strobes, three-stage sampled
    // =========================================================
    reg [2:0] cs_sync_ff;
    reg [2:0] rd_sync_ff;
    reg [2:0] wr_sync_ff;
    reg [7:0] addr_s1_ff;
    reg [7:0] addr_s2_ff;
    reg [7:0] addr_s3_ff;
    reg [7:0] wdata_s1_ff;
    reg [7:0] wdata_s2_ff;
    reg [7:0] wdata_s3_ff;
    reg wr_act_ff;
    // A strobe counts once the second and third stages agree
    wire rd_act = ~cs_sync_ff[2] & ~rd_sync_ff[2] & ~cs_sync_ff[1] & ~rd_sync_ff[1];
    wire wr_now = ~cs_sync_ff[2] & ~wr_sync_ff[2] & ~cs_sync_ff[1] & ~wr_sync_ff[1];
    // One write per low period of the write strobe
    wire wr_stb = wr_now & ~wr_act_ff;

    function wr_hit;
        input [7:0] a;
        input [7:0] target;
        begin
            wr_hit = (a == target);
        end
    endfunction

    always @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            cs_sync_ff <= 3'h7;
            rd_sync_ff <= 3'h7;
            wr_sync_ff <= 3'h7;
            addr_s1_ff <= 8'h00;
            addr_s2_ff <= 8'h00;
            addr_s3_ff <= 8'h00;
            wdata_s1_ff <= 8'h00;
            wdata_s2_ff <= 8'h00;
            wdata_s3_ff <= 8'h00;
            wr_act_ff <= 1'b0;
        end else begin
            cs_sync_ff <= {cs_sync_ff[1:0], I_CS_N};
            rd_sync_ff <= {rd_sync_ff[1:0], I_RD_N};
            wr_sync_ff <= {wr_sync_ff[1:0], I_WR_N};
            addr_s1_ff <= I_ADDR;
            addr_s2_ff <= addr_s1_ff;
            addr_s3_ff <= addr_s2_ff;
            wdata_s1_ff <= I_WDATA;
            wdata_s2_ff <= wdata_s1_ff;
            wdata_s3_ff <= wdata_s2_ff;
            wr_act_ff <= wr_now;
        end
    end

    wire wr_ctrl = wr_stb & wr_hit(addr_s3_ff, `CTRL_WR_ADDR);
    wire wr_tgl = wr_stb & wr_hit(addr_s3_ff, `TGL_WR_ADDR);
    wire wr_mps = wr_stb & wr_hit(addr_s3_ff, `MPS_WR_ADDR);

    // =========================================================
    // Endpoint state
    // =========================================================
    localparam [7:0] CTRL_RST = `CTRL_RESET;
    reg cfg_ff;
    reg stall_ff;
    reg dir_ff;
    reg seq_ff;
    reg [MPS_W-1:0] mps_ff;
    reg [7:0] rx_cnt_ff;
    reg [7:0] dma_cnt_ff;
    reg rx_over_ff;
    reg rx_ready_ff;
    reg tx_ready_ff;
    reg [1:0] hs_ff;
    reg hs_valid_ff;
    reg [1:0] nxt_hs;
    reg nxt_hs_valid;

    wire active = cfg_ff & ~I_BUS_RST;
    wire [7:0] mps_bytes = {{(8 - MPS_W){1'b0}}, mps_ff};       // [RQ9]
    wire rx_too_long = (rx_cnt_ff + 8'h01) > mps_bytes;
    wire rx_eop = I_RX_EOP & active & ~dir_ff;
    wire rx_bad = rx_eop & (rx_over_ff | (I_RX_BYTE & rx_too_long));
    wire seq_match = (I_RX_PID_DATA1 == seq_ff);
    // Accepted OUT packet: good length, not stalled, buffer free, expected PID
    wire rx_take = rx_eop & ~rx_bad & ~stall_ff & ~rx_ready_ff & seq_match;
    wire tx_full = (dma_cnt_ff + 8'h01) >= mps_bytes;
    wire tx_fill = I_DMA_BYTE & dir_ff & ~tx_ready_ff;
    // OUT data to a stalled endpoint is refused in either direction
    wire out_stalled = I_RX_EOP & active & stall_ff;
    wire in_refused = I_TOKEN & I_TOKEN_IN & active & (stall_ff | ~tx_ready_ff);

    // =========================================================
    // Control bits
    // =========================================================
    always @(posedge I_CLK) begin
        if (I_SYS_RST || I_BUS_RST) begin
            cfg_ff <= CTRL_RST[`CTRL_CFG_BIT];
            dir_ff <= CTRL_RST[`CTRL_DIR_BIT];
            stall_ff <= CTRL_RST[`CTRL_STALL_BIT];
        end else begin
            if (wr_ctrl) begin
                cfg_ff <= wdata_s3_ff[`CTRL_CFG_BIT];           // [RQ13]
                dir_ff <= wdata_s3_ff[`CTRL_DIR_BIT];           // [RQ2]
            end
            // Hardware stall wins over a software write of zero
            if (rx_bad)
                stall_ff <= 1'b1;                               // [RQ10]
            else if (wr_ctrl)
                stall_ff <= wdata_s3_ff[`CTRL_STALL_BIT];       // [RQ14]
        end
    end

    // Data sequence; a toggle-register write wins over an automatic flip
    always @(posedge I_CLK) begin
        if (I_SYS_RST || I_BUS_RST)
            seq_ff <= 1'b0;
        else if (wr_tgl && wdata_s3_ff[`TGL_BIT])
            seq_ff <= 1'b0;                                     // [RQ4]
        else if (I_HOST_ACK && active && dir_ff && !stall_ff)
            seq_ff <= ~seq_ff;                                  // [RQ5]
        else if (rx_take)
            seq_ff <= ~seq_ff;                                  // [RQ5]
    end

    // =========================================================
    // Receive and transmit buffers
    // =========================================================
    // Receive byte count; an oversize packet is flagged before its end
    always @(posedge I_CLK) begin
        if (I_SYS_RST || I_BUS_RST) begin
            rx_cnt_ff <= 8'h00;
            rx_over_ff <= 1'b0;
            rx_ready_ff <= 1'b0;
        end else begin
            if (rx_eop) begin
                rx_cnt_ff <= 8'h00;
                rx_over_ff <= 1'b0;
            end else if (I_RX_BYTE && active && !dir_ff) begin
                if (rx_too_long)
                    rx_over_ff <= 1'b1;
                else
                    rx_cnt_ff <= rx_cnt_ff + 8'h01;
            end
            if (rx_take)
                rx_ready_ff <= 1'b1;                            // [RQ3] [RQ10]
            else if (I_RX_CLR)
                rx_ready_ff <= 1'b0;
        end
    end

    // Transmit fill count; a completed fill wins over a clear
    always @(posedge I_CLK) begin
        if (I_SYS_RST || I_BUS_RST) begin
            dma_cnt_ff <= 8'h00;
            tx_ready_ff <= 1'b0;
        end else if (tx_fill && tx_full && !stall_ff) begin
            tx_ready_ff <= 1'b1;                                // [RQ11] [RQ3]
            dma_cnt_ff <= 8'h00;
        end else if (I_TX_CLR) begin
            dma_cnt_ff <= 8'h00;
            tx_ready_ff <= 1'b0;
        end else if (tx_fill) begin
            dma_cnt_ff <= dma_cnt_ff + 8'h01;
        end
    end

    // =========================================================
    // Handshake choice
    // =========================================================
    always @* begin
        nxt_hs_valid = 1'b0;
        nxt_hs = `HS_NONE;
        if (rx_eop) begin
            nxt_hs_valid = 1'b1;
            if (rx_bad || stall_ff)
                nxt_hs = `HS_STALL;                             // [RQ10] [RQ14]
            else if (rx_ready_ff)
                nxt_hs = `HS_NAK;
            else
                nxt_hs = `HS_ACK;
        end else if (out_stalled) begin
            nxt_hs_valid = 1'b1;
            nxt_hs = `HS_STALL;                                 // [RQ14]
        end else if (in_refused) begin
            nxt_hs_valid = 1'b1;
            nxt_hs = stall_ff ? `HS_STALL : `HS_NAK;            // [RQ14]
        end
    end

    always @(posedge I_CLK) begin
        if (I_SYS_RST || I_BUS_RST) begin
            hs_ff <= `HS_NONE;
            hs_valid_ff <= 1'b0;
        end else begin
            hs_ff <= nxt_hs;
            hs_valid_ff <= nxt_hs_valid;
        end
    end

    // Packet size survives bus reset; top bit not stored
    always @(posedge I_CLK) begin
        if (I_SYS_RST)
            mps_ff <= `MPS_RESET;
        else if (wr_mps)
            mps_ff <= wdata_s3_ff[MPS_W-1:0];                   // [RQ12] [RQ8]
    end

    // =========================================================
    // Read data and registered outputs
    // =========================================================
    reg [7:0] nxt_rdata;
    always @* begin
        nxt_rdata = 8'h00;
        if (rd_act) begin
            case (addr_s3_ff)
                `CTRL_RD_ADDR:
                    nxt_rdata = {cfg_ff, `CTRL_FIXED_VAL, dir_ff, stall_ff}; // [RQ1]
                `TGL_RD_ADDR:
                    nxt_rdata = 8'h00;                          // [RQ6] [RQ4]
                `MPS_RD_ADDR:
                    nxt_rdata = mps_bytes;                      // [RQ12]
                default:
                    nxt_rdata = 8'h00;
            endcase
        end
    end

    always @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_RDATA <= 8'h00;
            O_RESPOND <= 1'b0;
            O_HANDSHAKE <= `HS_NONE;
            O_HS_VALID <= 1'b0;
            O_TX_PID_DATA1 <= 1'b0;
            O_RX_READY <= 1'b0;
            O_TX_READY <= 1'b0;
            O_IRQ_OUTPUT <= 1'b0;
            O_DIR_TX <= 1'b0;
            O_STALLED <= 1'b0;
        end else begin
            O_RDATA <= nxt_rdata;
            O_RESPOND <= active;                                // [RQ13]
            O_HANDSHAKE <= hs_ff;
            O_HS_VALID <= hs_valid_ff;
            O_TX_PID_DATA1 <= seq_ff;
            O_RX_READY <= rx_ready_ff & ~stall_ff;              // [RQ3]
            O_TX_READY <= tx_ready_ff & ~stall_ff;              // [RQ3]
            O_IRQ_OUTPUT <= ~stall_ff & (rx_ready_ff | tx_ready_ff); // [RQ3]
            O_DIR_TX <= dir_ff;
            O_STALLED <= stall_ff;
        end
    end

endmodule
`default_nettype wire

// >>> tb/ep_one_assertions.sv
// Concurrent checks on the bulk endpoint one control block.
// Assumes binding to bulk_ep_one_ctrl; watches its ports only.
`timescale 1ns/1ns
`default_nettype none
module ep_one_assertions (
    input wire logic I_CLK, // Clock
    input wire logic I_SYS_RST, // Reset
    input wire logic I_BUS_RST, // Bus reset
    input wire logic I_TOKEN, // Token
    input wire logic I_TOKEN_IN, // IN token
    input wire logic I_RX_EOP, // End of packet
    input wire logic O_RESPOND, // Configured
    input wire logic [1:0] O_HANDSHAKE, // Handshake
    input wire logic O_HS_VALID, // Strobe
    input wire logic O_RX_READY, // Rx ready
    input wire logic O_TX_READY, // Tx ready
    input wire logic O_IRQ_OUTPUT, // Interrupt
    input wire logic O_STALLED // Stall
);
    // ==========
    // Properties
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    in_answer_a: assert property (
        I_TOKEN && I_TOKEN_IN && O_RESPOND && (O_STALLED || !O_TX_READY) |-> ##2 O_HS_VALID)
        else $error("no answer to IN token");
    stall_hs_a: assert property (
        O_STALLED && O_RESPOND && I_RX_EOP |-> ##2 O_HS_VALID && O_HANDSHAKE == 2'h3)
        else $error("no stall handshake");
    nak_in_a: assert property (
        I_TOKEN && I_TOKEN_IN && O_RESPOND && !O_STALLED && !O_TX_READY
        |-> ##2 O_HS_VALID && O_HANDSHAKE == 2'h2) else $error("no NAK when empty");
    stall_ready_a: assert property (
        O_STALLED && $past(O_STALLED) |-> !O_RX_READY && !O_TX_READY)
        else $error("ready while stalled");
    stall_irq_a: assert property (
        O_STALLED && $past(O_STALLED) |-> !O_IRQ_OUTPUT) else $error("irq while stalled");
    unconf_quiet_a: assert property (
        !O_RESPOND [*3] |-> !O_HS_VALID) else $error("handshake while unconfigured");
    hs_pulse_a: assert property (
        O_HS_VALID |=> !O_HS_VALID) else $error("handshake strobe too long");
    bus_clear_a: assert property (
        I_BUS_RST [*3] |-> !O_RESPOND && !O_STALLED && !O_RX_READY)
        else $error("bus reset left state");
endmodule
bind bulk_ep_one_ctrl ep_one_assertions chk_i (.I_CLK, .I_SYS_RST, .I_BUS_RST, .I_TOKEN,
    .I_TOKEN_IN, .I_RX_EOP, .O_RESPOND, .O_HANDSHAKE, .O_HS_VALID, .O_RX_READY,
    .O_TX_READY, .O_IRQ_OUTPUT, .O_STALLED);
`default_nettype wire

// >>> tb/usb_host_model.sv
// Host and DMA side of bulk endpoint one, as seen by the packet engine port.
// Assumes one clock; every strobe changes just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module usb_host_model (
    input wire logic i_clk, // Clock
    output var logic o_tok, // Token
    output var logic o_tok_in, // IN token
    output var logic o_rx_byte, // Byte
    output var logic o_rx_eop, // End of packet
    output var logic o_pid1, // DATA1 PID
    output var logic o_host_ack, // Host ACK
    output var logic o_dma_byte, // DMA byte
    output var logic o_tx_clr, // Tx emptied
    output var logic o_rx_clr // Rx read out
);
    initial {o_tok, o_tok_in, o_rx_byte, o_rx_eop, o_pid1} = 5'h00;
    initial {o_host_ack, o_dma_byte, o_tx_clr, o_rx_clr} = 4'h0;
    // Kind: 0 ack, 1 tx clear, 2 rx clear, 3 IN token, 4 DMA bytes, 5 OUT token
    task automatic strobe(input int k, input int n);
        @(posedge i_clk);
        o_host_ack <= k == 0;
        o_tx_clr <= k == 1;
        o_rx_clr <= k == 2;
        o_tok <= k == 3 || k == 5;
        o_tok_in <= k == 3;
        o_dma_byte <= k == 4;
        repeat (n) @(posedge i_clk);
        {o_host_ack, o_tx_clr, o_rx_clr, o_tok, o_tok_in, o_dma_byte} <= 6'h00;
    endtask
    task automatic out_pkt(input int n, input logic pid);
        strobe(5, 1);
        o_rx_byte <= 1'b1;
        repeat (n) @(posedge i_clk);
        o_rx_byte <= 1'b0;
        o_rx_eop <= 1'b1;
        o_pid1 <= pid;
        @(posedge i_clk);
        o_rx_eop <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the bulk endpoint one control block.
// Assumes the host model makes all packet and DMA traffic.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 1'b0, rst = 1'b1, bus_rst = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, got;
    logic [1:0] hs, hs_last = 2'h0;
    logic hs_v, respond, pid_seq, rx_rdy, tx_rdy, irq, dir_tx, stalled;
    logic tok, tok_in, rx_byte, rx_eop, pid1, host_ack, dma_byte, tx_clr, rx_clr;
    int error_cnt = 0, compares = 0, hs_n = 0, n0 = 0;
    // Write address, write data, read address, expected read data
    logic [31:0] rows [0:5] = '{32'h64ffe49b, 32'h6400e418, 32'h65ffe500, 32'h66ffe67f,
        32'h6608e608, 32'h2a55e608};
    bulk_ep_one_ctrl dut (.I_CLK(clk), .I_SYS_RST(rst), .I_BUS_RST(bus_rst), .I_CS_N(cs_n),
        .I_RD_N(rd_n), .I_WR_N(wr_n), .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata),
        .I_TOKEN(tok), .I_TOKEN_IN(tok_in), .I_RX_BYTE(rx_byte), .I_RX_EOP(rx_eop),
        .I_RX_PID_DATA1(pid1), .I_HOST_ACK(host_ack), .I_DMA_BYTE(dma_byte),
        .I_TX_CLR(tx_clr), .I_RX_CLR(rx_clr), .O_RESPOND(respond), .O_HANDSHAKE(hs),
        .O_HS_VALID(hs_v), .O_TX_PID_DATA1(pid_seq), .O_RX_READY(rx_rdy),
        .O_TX_READY(tx_rdy), .O_IRQ_OUTPUT(irq), .O_DIR_TX(dir_tx), .O_STALLED(stalled));
    usb_host_model host (.i_clk(clk), .o_tok(tok), .o_tok_in(tok_in), .o_rx_byte(rx_byte),
        .o_rx_eop(rx_eop), .o_pid1(pid1), .o_host_ack(host_ack), .o_dma_byte(dma_byte),
        .o_tx_clr(tx_clr), .o_rx_clr(rx_clr));
    always #5 clk = ~clk;
    always @(posedge clk) if (hs_v === 1'b1) begin
        hs_last <= hs;
        hs_n <= hs_n + 1;
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One register access; strobes held six edges, then five edges idle
    task acc(input logic [7:0] a, input logic [7:0] d, input logic wr);
        @(posedge clk);
        {cs_n, rd_n, wr_n} <= {1'b0, wr, !wr};
        addr <= a;
        wdata <= d;
        repeat (6) @(posedge clk);
        got = rdata;
        {cs_n, rd_n, wr_n} <= 3'h7;
        repeat (5) @(posedge clk);
    endtask
    task hs_chk(input logic [7:0] exp);
        repeat (5) @(posedge clk);
        chk({6'h00, hs_last}, exp);
        chk(hs_n[7:0], n0[7:0] + 8'h01);
        n0 = hs_n;
    endtask
    task print_verdict;
        if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        print_verdict;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            acc(rows[i][31:24], rows[i][23:16], 1'b1);
            acc(rows[i][15:8], 8'h00, 1'b0);
            chk(got, rows[i][7:0]);
        end
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        acc(8'he4, 8'h00, 1'b0);
        chk(got, 8'h18);
        acc(8'he6, 8'h00, 1'b0);
        chk(got, 8'h40);
        acc(8'h66, 8'h08, 1'b1);
        acc(8'h64, 8'h80, 1'b1);
        host.out_pkt(8, 1'b0);
        hs_chk(8'h01);
        chk({rx_rdy, pid_seq, irq}, 8'h07);
        host.strobe(2, 1);
        host.out_pkt(9, 1'b1);
        hs_chk(8'h03);
        chk({rx_rdy, stalled, irq, pid_seq}, 8'h05);
        host.strobe(3, 1);
        hs_chk(8'h03);
        host.out_pkt(1, 1'b1);
        hs_chk(8'h03);
        acc(8'h65, 8'h01, 1'b1);
        chk(pid_seq, 8'h00);
        acc(8'h64, 8'h82, 1'b1);
        host.strobe(3, 1);
        hs_chk(8'h02);
        host.strobe(4, 7);
        chk(tx_rdy, 8'h00);
        host.strobe(4, 1);
        repeat (3) @(posedge clk);
        chk({dir_tx, tx_rdy, irq, stalled}, 8'h0e);
        host.strobe(0, 1);
        host.strobe(1, 1);
        repeat (3) @(posedge clk);
        chk({tx_rdy, pid_seq}, 8'h01);
        acc(8'h64, 8'h00, 1'b1);
        n0 = hs_n;
        host.out_pkt(8, 1'b1);
        repeat (5) @(posedge clk);
        chk(hs_n[7:0], n0[7:0]);
        acc(8'h64, 8'h81, 1'b1);
        @(posedge clk) bus_rst <= 1'b1;
        repeat (3) @(posedge clk);
        bus_rst <= 1'b0;
        acc(8'he4, 8'h00, 1'b0);
        chk(got, 8'h18);
        print_verdict;
    end
endmodule
`default_nettype wire
